// ==== ppsm_defs.vh ====
/*
 * Constants for the parallel-port strap pin multiplexer.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PPSM_DEFS_VH
`define PPSM_DEFS_VH

// ****************************************
// Pin function codes
// ****************************************
`define PPSM_FUNC_GPIO      1'h0
`define PPSM_FUNC_MEM       1'h1

// ****************************************
// Shared pin layout
// ****************************************
`define PPSM_NUM_PINS       5
`define PPSM_PIN_BYTE_EN_TWO    0
`define PPSM_PIN_BYTE_EN_THREE  1
`define PPSM_PIN_CLK_EN         2
`define PPSM_PIN_OUT_EN_SPACE3  3
`define PPSM_PIN_HOLD           4

// ****************************************
// Memory output idle level after reset
// ****************************************
`define PPSM_MEM_IDLE       1'h1

// ****************************************
// Synchroniser depth
// ****************************************
`define PPSM_SYNC_STAGES    2

`endif

// ==== ppsm_sync.v ====
/*
 * Two-flop synchroniser for pin-level inputs.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "ppsm_defs.vh"

module ppsm_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    // ****************************************
    // Two stages
    // ****************************************
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] stable_r;

    always @(posedge clock) begin
        if (!rst_n) begin
            meta_r   <= {WIDTH{1'h0}};
            stable_r <= {WIDTH{1'h0}};
        end else begin
            meta_r   <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule

// ==== ppsm_pin_mux.v ====
/*
 * Reset-strapped multiplexer for five shared parallel-port pins.
 * Pins 0-3 are parallel I/O lines or external memory control signals; pin four is a parallel I/O line or the bus hold request input.
 * Assumes pins resolve through tristate logic outside; single clock.
 */
`timescale 1ns/1ps
`include "ppsm_defs.vh"

module ppsm_pin_mux (
    input  wire       clock,
    input  wire       rst_n,
    input  wire       function_strap_input,
    input  wire [4:0] shared_pin_in,
    output wire [4:0] shared_pin_out,
    output wire [4:0] shared_pin_oe,
    input  wire [4:0] gpio_out,
    input  wire [4:0] gpio_dir_out,
    output wire [4:0] gpio_in,
    input  wire       mem_byte_enable_two,
    input  wire       mem_byte_enable_three,
    input  wire       sync_dram_clock_enable,
    input  wire       sync_output_enable_space3,
    input  wire       mem_outputs_valid,
    output wire       bus_takeover_request,
    input  wire       hold_granted,
    output wire       bus_takeover_ack,
    output wire       mem_bus_float,
    output wire       mem_mode
);

    // ****************************************
    // Local codes
    // ****************************************
    localparam [1:0] HOLD_OFF = 2'h0;
    localparam [1:0] HOLD_ON  = 2'h1;

    // ****************************************
    // Functions
    // ****************************************
    // Word passed only while its condition holds
    function [4:0] mode_gate;
        input       keep_word;
        input [4:0] word;
        begin
            if (keep_word) begin
                mode_gate = word;
            end else begin
                mode_gate = 5'h00;
            end
        end
    endfunction

    // Memory controls in pin order, idle high until valid
    function [4:0] mem_pin_word;
        input valid;
        input byte_two;
        input byte_three;
        input clk_en;
        input out_en;
        begin
            mem_pin_word                          = 5'h00;
            mem_pin_word[`PPSM_PIN_BYTE_EN_TWO]   = valid ? byte_two   : `PPSM_MEM_IDLE;
            mem_pin_word[`PPSM_PIN_BYTE_EN_THREE] = valid ? byte_three : `PPSM_MEM_IDLE;
            mem_pin_word[`PPSM_PIN_CLK_EN]        = valid ? clk_en     : `PPSM_MEM_IDLE;
            mem_pin_word[`PPSM_PIN_OUT_EN_SPACE3] = valid ? out_en     : `PPSM_MEM_IDLE;
        end
    endfunction

    // Memory pins driven unless handed over; hold pin never driven
    function [4:0] mem_oe_word;
        input float_bus;
        begin
            mem_oe_word                 = {5{~float_bus}};
            mem_oe_word[`PPSM_PIN_HOLD] = 1'h0;
        end
    endfunction

    // ****************************************
    // Strap synchroniser
    // ****************************************
    // No reset: strap must be seen while reset is held
    reg strap_meta_r;
    reg strap_sync_r;

    always @(posedge clock) begin
        strap_meta_r <= function_strap_input;
        strap_sync_r <= strap_meta_r;
    end

    // ****************************************
    // Pin synchroniser
    // ****************************************
    wire [4:0] pin_sync;

    ppsm_sync #(
        .WIDTH (`PPSM_NUM_PINS)
    ) ppsm_sync_i (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (shared_pin_in),
        .sync_out (pin_sync)
    );

    // ****************************************
    // Strap capture
    // ****************************************
    reg func_sel_r;
    reg in_reset_r;
    reg drive_en_r;

    // Sample during reset, freeze on release
    always @(posedge clock) begin
        if (!rst_n) begin
            in_reset_r <= 1'h1;
            drive_en_r <= 1'h0;
            func_sel_r <= strap_sync_r;
        end else begin
            in_reset_r <= 1'h0;
            drive_en_r <= 1'h1;
            func_sel_r <= func_sel_r;
        end
    end

    assign mem_mode = func_sel_r;

    // ****************************************
    // Hold handshake
    // ****************************************
    reg  [1:0] hold_state_r;
    reg  [1:0] hold_state_nxt;
    wire       hold_want;

    // Hold request read only in memory mode
    assign bus_takeover_request = (func_sel_r == `PPSM_FUNC_MEM) & drive_en_r
                                  & pin_sync[`PPSM_PIN_HOLD];
    assign hold_want            = bus_takeover_request & hold_granted;

    always @* begin
        case (hold_state_r)
            HOLD_OFF: begin
                if (hold_want) begin
                    hold_state_nxt = HOLD_ON;
                end else begin
                    hold_state_nxt = HOLD_OFF;
                end
            end
            HOLD_ON: begin
                // Stay while both sides still want it
                if (hold_want) begin
                    hold_state_nxt = HOLD_ON;
                end else begin
                    hold_state_nxt = HOLD_OFF;
                end
            end
            default: begin
                hold_state_nxt = HOLD_OFF;
            end
        endcase
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            hold_state_r <= HOLD_OFF;
        end else begin
            hold_state_r <= hold_state_nxt;
        end
    end

    // Same edge as the memory pin enables drop
    assign bus_takeover_ack = (hold_state_r == HOLD_ON);
    assign mem_bus_float    = (hold_state_r == HOLD_ON);

    // ****************************************
    // Parallel I/O path
    // ****************************************
    reg  [4:0] gpio_dir_r;
    reg  [4:0] gpio_dir_nxt;
    reg  [4:0] gpio_in_r;
    reg  [4:0] gpio_in_nxt;

    // Direction kept at input on the release edge
    always @* begin
        gpio_dir_nxt = mode_gate(~in_reset_r, gpio_dir_out);
        gpio_in_nxt  = mode_gate(func_sel_r == `PPSM_FUNC_GPIO, pin_sync);
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            gpio_dir_r <= 5'h00;
            gpio_in_r  <= 5'h00;
        end else begin
            gpio_dir_r <= gpio_dir_nxt;
            gpio_in_r  <= gpio_in_nxt;
        end
    end

    assign gpio_in = gpio_in_r;

    // ****************************************
    // Pin multiplexing
    // ****************************************
    reg  [4:0] pin_out_r;
    reg  [4:0] pin_out_nxt;
    reg  [4:0] pin_oe_r;
    reg  [4:0] pin_oe_nxt;

    always @* begin
        if (func_sel_r == `PPSM_FUNC_MEM) begin
            pin_out_nxt = mem_pin_word(mem_outputs_valid, mem_byte_enable_two, mem_byte_enable_three,
                                       sync_dram_clock_enable, sync_output_enable_space3);
            pin_oe_nxt  = mem_oe_word(hold_state_nxt == HOLD_ON);
        end else begin
            pin_out_nxt = gpio_out;
            pin_oe_nxt  = mode_gate(~in_reset_r, gpio_dir_r);
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            pin_out_r <= 5'h00;
            pin_oe_r  <= 5'h00;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

    assign shared_pin_out = pin_out_r;
    assign shared_pin_oe  = pin_oe_r;

endmodule

// ==== ppsm_pin_mux_props.sv ====
/* Checker for ppsm_pin_mux.
   Sees only the mux ports; bound below. */
`timescale 1ns/1ps
module ppsm_pin_mux_props (
    input wire       clock,
    input wire       rst_n,
    input wire [4:0] shared_pin_out,
    input wire [4:0] shared_pin_oe,
    input wire       mem_outputs_valid,
    input wire       bus_takeover_request,
    input wire       hold_granted,
    input wire       bus_takeover_ack,
    input wire       mem_bus_float,
    input wire       mem_mode
);
// ******
// Properties
// ******
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
sequence s_hold;
    bus_takeover_request && hold_granted;
endsequence
a_reset_float: assert property (disable iff (1'b0) !rst_n |=> shared_pin_oe == 5'h00)
    else $error("pins driven in reset");
a_ack_follows_req: assert property (s_hold |=> bus_takeover_ack)
    else $error("ack missing");
a_no_spurious_ack: assert property (!bus_takeover_request |=> !bus_takeover_ack)
    else $error("ack without request");
a_float_eq_ack: assert property (mem_bus_float == bus_takeover_ack)
    else $error("float differs from ack");
a_ack_floats_bus: assert property (bus_takeover_ack |-> shared_pin_oe[3:0] == 4'h0)
    else $error("bus driven in hold");
a_mem_oe_tracks: assert property (mem_mode && $past(rst_n) |-> shared_pin_oe[3:0] == {4{!bus_takeover_ack}})
    else $error("memory pin enable wrong");
a_hold_gpio_blocked: assert property (!mem_mode |-> !bus_takeover_request)
    else $error("hold seen in gpio mode");
a_hold_pin_input: assert property (mem_mode |-> !shared_pin_oe[4])
    else $error("hold pin driven");
a_mode_stays_put: assert property ($past(rst_n, 2) |-> $stable(mem_mode))
    else $error("mode changed");
a_mem_idle_high: assert property (mem_mode && !mem_outputs_valid && !bus_takeover_ack && $past(rst_n, 2)
    |=> shared_pin_out[3:0] == 4'hf)
    else $error("idle level not high");
endmodule
bind ppsm_pin_mux ppsm_pin_mux_props ppsm_pin_mux_props_i (.clock(clock), .rst_n(rst_n),
    .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe), .mem_outputs_valid(mem_outputs_valid),
    .bus_takeover_request(bus_takeover_request), .hold_granted(hold_granted),
    .bus_takeover_ack(bus_takeover_ack), .mem_bus_float(mem_bus_float), .mem_mode(mem_mode));

// ==== ppsm_partner.sv ====
/* Far-side model: external host and pin levels.
   Assumes pins resolve by output enable. */
`timescale 1ns/1ps
module ppsm_partner (
    input  wire [4:0] pin_out,
    input  wire [4:0] pin_oe,
    input  wire [3:0] park,
    input  wire       hold_req,
    output wire [4:0] pin_level
);
// ******
// Pin resolution
// ******
// Host drives pin four to ask for the bus
assign pin_level = (pin_oe & pin_out) | (~pin_oe & {hold_req, park});
endmodule

// ==== ppsm_pin_mux_bench.sv ====
/* Self-checking bench for ppsm_pin_mux.
   Assumes ppsm_partner on the pins. */
`timescale 1ns/1ps
module ppsm_pin_mux_bench;
reg        clock, rst_n, strap, req, grant, valid;
reg  [3:0] park, mc;
reg  [4:0] go, gd;
wire [4:0] po, pe, gi, lvl;
wire       hr, ack, flt, mm;
integer    n_mismatch = 0, check_count = 0;
// ******
// Harness
// ******
ppsm_pin_mux ppsm_pin_mux_i (.clock(clock), .rst_n(rst_n), .function_strap_input(strap), .shared_pin_in(lvl),
    .shared_pin_out(po), .shared_pin_oe(pe), .gpio_out(go), .gpio_dir_out(gd), .gpio_in(gi),
    .mem_byte_enable_two(mc[0]), .mem_byte_enable_three(mc[1]), .sync_dram_clock_enable(mc[2]),
    .sync_output_enable_space3(mc[3]), .mem_outputs_valid(valid), .bus_takeover_request(hr),
    .hold_granted(grant), .bus_takeover_ack(ack), .mem_bus_float(flt), .mem_mode(mm));
ppsm_partner ppsm_partner_i (.pin_out(po), .pin_oe(pe), .park(park), .hold_req(req), .pin_level(lvl));
initial begin
    clock = 0;
    forever #10 clock = ~clock;
end
task chk(input string what, input [4:0] exp, input [4:0] got);
    begin
        check_count = check_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, got);
        end
    end
endtask
task wait_look(input integer n);
    begin
        repeat (n) @(posedge clock);
        @(negedge clock);
    end
endtask
task boot(input m);
    begin
        @(posedge clock);
        rst_n <= 0;
        strap <= m;
        wait_look(8);
        chk("oe in reset", 5'h00, pe);
        @(posedge clock);
        rst_n <= 1;
        strap <= ~m;
        wait_look(3);
        chk("mode", {4'h0, m}, {4'h0, mm});
    end
endtask
task t_gpio;
    begin
        boot(0);
        chk("gpio oe", 5'h00, pe);
        @(posedge clock);
        park <= 4'ha;
        req <= 1;
        gd <= 5'h03;
        go <= 5'h01;
        wait_look(5);
        chk("gpio in", 5'h19, gi);
        chk("gpio oe dir", 5'h03, pe);
        chk("hold gpio", 5'h00, {4'h0, hr});
        @(posedge clock);
        req <= 0;
        $display("gpio test done");
    end
endtask
task t_mem;
    begin
        valid <= 0;
        boot(1);
        chk("mem oe", 5'h0f, pe);
        chk("mem idle", 5'h0f, {1'b0, po[3:0]});
        @(posedge clock);
        valid <= 1;
        mc <= 4'hb;
        wait_look(2);
        chk("mem ctl", 5'h0b, {1'b0, po[3:0]});
        @(posedge clock);
        req <= 1;
        grant <= 1;
        wait_look(5);
        chk("ack float", 5'h03, {3'h0, ack, flt});
        chk("hold oe", 5'h00, pe);
        @(posedge clock);
        req <= 0;
        grant <= 0;
        wait_look(4);
        chk("ack drop", 5'h00, {4'h0, ack});
        $display("mem test done");
    end
endtask
task finish_test;
    begin
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
endtask
initial begin
    {rst_n, strap, req, grant, valid} = 5'h00;
    {park, mc, go, gd} = 18'h0_0000;
    t_gpio;
    t_mem;
    finish_test;
end
initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    finish_test;
end
endmodule
